// *** verilog/smpc_pkg.sv ***
// constants and types for the stop mode power controller
package smpc_pkg;
  // ----------------------------------------
  // stop depth requests
  // ----------------------------------------
  localparam logic [1:0] DEPTH_STOP1 = 2'h0;
  localparam logic [1:0] DEPTH_STOP2 = 2'h1;
  localparam logic [1:0] DEPTH_STOP3 = 2'h2;
  localparam logic [1:0] DEPTH_STOP4 = 2'h3;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DEBUG_CTRL = 4'h8;
  // ----------------------------------------
  // mode control field positions
  // ----------------------------------------
  localparam int MC_DEPTH_LSB = 0;
  localparam int MC_LOWVOLT_DETECT_ENABLE_BIT = 2;
  localparam int MC_LOWVOLT_STOP_ENABLE_BIT = 3;
  localparam int MC_STOP_INSTRUCTION_ENABLE_BIT = 4;
  localparam int MC_ACK_BIT = 5;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  // ----------------------------------------
  // status field positions
  // ----------------------------------------
  localparam int ST_POWERDOWN_RECOVERY_FLAG_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_LVD_BIT = 2;
  localparam int ST_STOPPED_BIT = 3;
  localparam int ST_DEPTH_LSB = 4;
  // ----------------------------------------
  // debug command codes
  // ----------------------------------------
  localparam logic [1:0] DBG_READ_STATUS = 2'h0;
  localparam logic [1:0] DBG_WRITE_CONTROL = 2'h1;
  localparam logic [1:0] DBG_MEM_STATUS = 2'h2;
  localparam logic [1:0] DBG_BACKGROUND = 2'h3;
  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAKE} smpc_state_t;
endpackage

// *** verilog/smpc_debug_port.sv ***
// debug status/control register reachable only through debug commands
`timescale 1ns/1ps
module smpc_debug_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // debug command
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic [7:0] cmd_data,
  // device state
  input wire logic stopped,
  // results
  output logic [7:0] resp_data,
  output logic resp_valid,
  output logic resp_stop_error,
  output logic debug_entry_enable,
  output logic background_req
);
  logic [7:0] debug_status_control_reg;

  assign debug_entry_enable = debug_status_control_reg[7];

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      debug_status_control_reg <= 8'h00;
    end else if (cmd_valid && cmd_code == smpc_pkg::DBG_WRITE_CONTROL) begin
      debug_status_control_reg <= cmd_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      resp_data <= 8'h00;
      resp_valid <= 1'b0;
      resp_stop_error <= 1'b0;
      background_req <= 1'b0;
    end else begin
      resp_valid <= cmd_valid && (cmd_code == smpc_pkg::DBG_READ_STATUS || cmd_code == smpc_pkg::DBG_MEM_STATUS);
      resp_stop_error <= cmd_valid && cmd_code == smpc_pkg::DBG_MEM_STATUS && stopped;
      resp_data <= (cmd_valid && cmd_code == smpc_pkg::DBG_READ_STATUS) ? debug_status_control_reg : 8'h00;
      background_req <= cmd_valid && cmd_code == smpc_pkg::DBG_BACKGROUND && debug_entry_enable;
    end
  end
endmodule // smpc_debug_port

// *** verilog/smpc_top.sv ***
// stop mode power controller top level
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module smpc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core events
  input wire logic stop_exec,
  input wire logic wake_reset_pin,
  input wire logic wake_irq_pin,
  input wire logic supply_rearmed_pin,
  input wire logic periph_enabled,
  // debug command port
  input wire logic dbg_cmd_valid,
  input wire logic [1:0] dbg_cmd_code,
  input wire logic [7:0] dbg_cmd_data,
  output logic [7:0] dbg_resp_data,
  output logic dbg_resp_valid,
  output logic dbg_resp_stop_error,
  // power and clock controls
  output logic regulator_on,
  output logic regulator_standby,
  output logic param_regs_on,
  output logic high_freq_oscillator_on,
  output logic core_on,
  output logic core_standby,
  output logic flash_on,
  output logic flash_standby,
  output logic ram_on,
  output logic timer_pwm_unit_clk_on,
  output logic periph_clk_on,
  output logic wakeup_lf_clk_on,
  output logic sys_clk_on,
  output logic debug_clk_on,
  // pins and restart
  output logic pin_latch_hold,
  output logic pins_hiz,
  output logic pin_port_ctrl,
  output logic low_voltage_detect,
  output logic take_reset_vector,
  output logic take_irq_vector,
  output logic illegal_opcode_reset,
  output logic halted_debug_state
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic wake_reset;
  logic wake_irq;
  logic supply_rearmed;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {supply_rearmed_pin, wake_irq_pin, wake_reset_pin};
      sync_b <= sync_a;
    end
  end
  assign wake_reset = sync_b[0];
  assign wake_irq = sync_b[1];
  assign supply_rearmed = sync_b[2];

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [7:0] power_mode_control;
  logic powerdown_recovery_flag;
  logic stopped_flag;
  logic [1:0] active_depth;
  logic keep_clocks;
  logic debug_entry_enable;
  logic background_req;
  smpc_pkg::smpc_state_t state;
  logic [1:0] next_depth;
  logic enter_stop;
  logic wake_now;
  logic deep;

  function automatic logic [1:0] resolve_depth(input logic [1:0] req, input logic lv_stop, input logic dbg);
    // redirect to stop4, regulator stays active
    if (lv_stop || dbg) begin
      resolve_depth = smpc_pkg::DEPTH_STOP4;
    end else begin
      resolve_depth = req;
    end
  endfunction

  wire lv_in_stop = power_mode_control[smpc_pkg::MC_LOWVOLT_DETECT_ENABLE_BIT] && power_mode_control[smpc_pkg::MC_LOWVOLT_STOP_ENABLE_BIT];
  wire ack_write = reg_wr && reg_addr == smpc_pkg::ADDR_MODE_CTRL && reg_wdata[smpc_pkg::MC_ACK_BIT];

  always_comb begin
    next_depth = resolve_depth(power_mode_control[1:0], lv_in_stop, debug_entry_enable);
  end
  assign enter_stop = state == smpc_pkg::ST_RUN && stop_exec && power_mode_control[smpc_pkg::MC_STOP_INSTRUCTION_ENABLE_BIT];
  assign deep = active_depth == smpc_pkg::DEPTH_STOP1 || active_depth == smpc_pkg::DEPTH_STOP2;
  assign wake_now = state == smpc_pkg::ST_STOP && (wake_reset || wake_irq || background_req) &&
                    (active_depth != smpc_pkg::DEPTH_STOP1 || supply_rearmed);

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      power_mode_control <= smpc_pkg::MODE_CTRL_RESET;
    end else if (state == smpc_pkg::ST_WAKE && deep) begin
      power_mode_control <= smpc_pkg::MODE_CTRL_RESET;
    end else if (reg_wr && reg_addr == smpc_pkg::ADDR_MODE_CTRL) begin
      power_mode_control <= {3'h0, reg_wdata[4:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == smpc_pkg::ADDR_MODE_CTRL) begin
      reg_rdata <= power_mode_control;
    end else if (reg_rd && reg_addr == smpc_pkg::ADDR_STATUS) begin
      reg_rdata <= {2'h0, active_depth, stopped_flag, low_voltage_detect, pin_latch_hold, powerdown_recovery_flag};
    end else if (reg_rd && reg_addr == smpc_pkg::ADDR_DEBUG_CTRL) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // stop sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= smpc_pkg::ST_RUN;
      active_depth <= smpc_pkg::DEPTH_STOP1;
      keep_clocks <= 1'b0;
      stopped_flag <= 1'b0;
    end else begin
      case (state)
        smpc_pkg::ST_RUN: begin
          if (enter_stop) begin
            state <= smpc_pkg::ST_STOP;
            active_depth <= next_depth;
            keep_clocks <= debug_entry_enable;
            stopped_flag <= 1'b1;
          end
        end
        smpc_pkg::ST_STOP: begin
          if (wake_now) begin
            state <= smpc_pkg::ST_WAKE;
          end
        end
        default: begin
          state <= smpc_pkg::ST_RUN;
          if (deep) begin
            active_depth <= smpc_pkg::DEPTH_STOP1;
          end
          keep_clocks <= 1'b0;
          stopped_flag <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      illegal_opcode_reset <= 1'b0;
    end else begin
      illegal_opcode_reset <= state == smpc_pkg::ST_RUN && stop_exec && !power_mode_control[smpc_pkg::MC_STOP_INSTRUCTION_ENABLE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      take_reset_vector <= 1'b0;
      take_irq_vector <= 1'b0;
      halted_debug_state <= 1'b0;
    end else begin
      take_reset_vector <= wake_now && (wake_reset || deep);
      take_irq_vector <= wake_now && !wake_reset && !deep && !background_req;
      if (wake_now && background_req && !wake_reset) begin
        halted_debug_state <= 1'b1;
      end else if (enter_stop) begin
        halted_debug_state <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // low voltage and pin latches
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      low_voltage_detect <= 1'b0;
    end else if (enter_stop && next_depth == smpc_pkg::DEPTH_STOP1) begin
      low_voltage_detect <= 1'b1;
    end else if (supply_rearmed) begin
      low_voltage_detect <= 1'b0;
    end
  end

  // flag and latch held until ack
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      powerdown_recovery_flag <= 1'b0;
      pin_latch_hold <= 1'b0;
    end else begin
      if (state == smpc_pkg::ST_WAKE && active_depth == smpc_pkg::DEPTH_STOP2) begin
        powerdown_recovery_flag <= 1'b1;
      end else if (ack_write) begin
        powerdown_recovery_flag <= 1'b0;
      end
      if (enter_stop && next_depth == smpc_pkg::DEPTH_STOP2) begin
        pin_latch_hold <= 1'b1;
      end else if (ack_write && state == smpc_pkg::ST_RUN) begin
        pin_latch_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_port_ctrl <= 1'b0;
    end else if (ack_write && pin_latch_hold && state == smpc_pkg::ST_RUN) begin
      pin_port_ctrl <= !periph_enabled;
    end else if (periph_enabled) begin
      pin_port_ctrl <= 1'b0;
    end
  end

  // ----------------------------------------
  // power and clock controls
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn || state != smpc_pkg::ST_STOP) begin
      regulator_on <= 1'b1;
      regulator_standby <= 1'b0;
      param_regs_on <= 1'b1;
      high_freq_oscillator_on <= 1'b1;
      core_on <= 1'b1;
      core_standby <= 1'b0;
      flash_on <= 1'b1;
      flash_standby <= 1'b0;
      ram_on <= 1'b1;
      timer_pwm_unit_clk_on <= 1'b1;
      periph_clk_on <= 1'b1;
      wakeup_lf_clk_on <= 1'b1;
      sys_clk_on <= 1'b1;
      debug_clk_on <= 1'b1;
      pins_hiz <= 1'b0;
    end else begin
      regulator_on <= active_depth == smpc_pkg::DEPTH_STOP4;
      regulator_standby <= active_depth != smpc_pkg::DEPTH_STOP4;
      param_regs_on <= 1'b1;
      high_freq_oscillator_on <= 1'b0;
      core_on <= 1'b0;
      core_standby <= !deep;
      flash_on <= 1'b0;
      flash_standby <= !deep;
      timer_pwm_unit_clk_on <= 1'b0;
      ram_on <= active_depth != smpc_pkg::DEPTH_STOP1;
      periph_clk_on <= 1'b0;
      wakeup_lf_clk_on <= 1'b1;
      sys_clk_on <= keep_clocks;
      debug_clk_on <= keep_clocks;
      pins_hiz <= active_depth == smpc_pkg::DEPTH_STOP1;
    end
  end

  // ----------------------------------------
  // debug command port
  // ----------------------------------------
  smpc_debug_port u_debug (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .cmd_valid(dbg_cmd_valid),
    .cmd_code(dbg_cmd_code),
    .cmd_data(dbg_cmd_data),
    .stopped(stopped_flag),
    .resp_data(dbg_resp_data),
    .resp_valid(dbg_resp_valid),
    .resp_stop_error(dbg_resp_stop_error),
    .debug_entry_enable(debug_entry_enable),
    .background_req(background_req)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_enter_stop1;
    enter_stop && next_depth == smpc_pkg::DEPTH_STOP1;
  endsequence

  AST_STOP1_LVD: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_enter_stop1 |=> low_voltage_detect) else $error("stop1 entry did not assert detect");
  AST_REDIRECT: assert property (@(posedge sys_clk) disable iff (!rstn)
    enter_stop && (lv_in_stop || debug_entry_enable) |=> active_depth == smpc_pkg::DEPTH_STOP4)
    else $error("deep stop not redirected");
  AST_ILLEGAL: assert property (@(posedge sys_clk) disable iff (!rstn)
    state == smpc_pkg::ST_RUN && stop_exec && !power_mode_control[smpc_pkg::MC_STOP_INSTRUCTION_ENABLE_BIT] |=>
    illegal_opcode_reset && state == smpc_pkg::ST_RUN) else $error("stop without enable not refused");
  AST_HFO_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    state == smpc_pkg::ST_STOP && $past(state) == smpc_pkg::ST_STOP |-> !high_freq_oscillator_on && param_regs_on)
    else $error("oscillator on in stop");
  AST_RESET_PRIO: assert property (@(posedge sys_clk) disable iff (!rstn)
    wake_now && wake_reset |=> take_reset_vector && !take_irq_vector) else $error("reset lost priority");
  AST_STOP1_HIZ: assert property (@(posedge sys_clk) disable iff (!rstn)
    state == smpc_pkg::ST_STOP && active_depth == smpc_pkg::DEPTH_STOP1 |=> pins_hiz || state != smpc_pkg::ST_STOP)
    else $error("stop1 pins not high impedance");
  AST_POWERDOWN_RECOVERY_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
    state == smpc_pkg::ST_WAKE && active_depth == smpc_pkg::DEPTH_STOP2 |=> powerdown_recovery_flag && pin_latch_hold)
    else $error("recovery flag not set");
  AST_STOP3_VEC: assert property (@(posedge sys_clk) disable iff (!rstn)
    wake_now && !deep && wake_irq && !wake_reset && !background_req |=> take_irq_vector)
    else $error("interrupt vector not taken");
  AST_PERIPH_CLK: assert property (@(posedge sys_clk) disable iff (!rstn)
    state == smpc_pkg::ST_STOP ##1 state == smpc_pkg::ST_STOP |-> !periph_clk_on && wakeup_lf_clk_on)
    else $error("peripheral clock running in stop");
endmodule // smpc_top

// *** verif/smpc_tb_top.sv ***
// directed testbench for the stop mode power controller
`timescale 1ns/1ps
module smpc_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stop_exec = 1'b0;
  logic wake_reset_pin = 1'b0;
  logic wake_irq_pin = 1'b0;
  logic supply_rearmed_pin = 1'b0;
  logic periph_enabled = 1'b0;
  logic dbg_cmd_valid = 1'b0;
  logic [1:0] dbg_cmd_code = 2'h0;
  logic [7:0] dbg_cmd_data = 8'h00;
  logic [7:0] reg_rdata, dbg_resp_data, rdv;
  logic dbg_resp_valid, dbg_resp_stop_error;
  logic regulator_on, regulator_standby, param_regs_on, high_freq_oscillator_on, core_on, core_standby;
  logic flash_on, flash_standby, ram_on, timer_pwm_unit_clk_on, periph_clk_on, wakeup_lf_clk_on;
  logic sys_clk_on, debug_clk_on, pin_latch_hold, pins_hiz, pin_port_ctrl, low_voltage_detect;
  logic take_reset_vector, take_irq_vector, illegal_opcode_reset, halted_debug_state;
  logic [2:0] seen;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  wire [7:0] pwr = {regulator_standby, core_on, core_standby, flash_on, flash_standby, ram_on,
                    high_freq_oscillator_on, param_regs_on};
  wire [7:0] clks = {timer_pwm_unit_clk_on, periph_clk_on, wakeup_lf_clk_on, sys_clk_on, debug_clk_on,
                     pins_hiz, low_voltage_detect, pin_latch_hold};
  wire [2:0] pulses = {take_reset_vector, take_irq_vector, illegal_opcode_reset};

  always #12.5 sys_clk = ~sys_clk;

  smpc_top dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_exec(stop_exec), .wake_reset_pin(wake_reset_pin),
    .wake_irq_pin(wake_irq_pin), .supply_rearmed_pin(supply_rearmed_pin), .periph_enabled(periph_enabled),
    .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd_code(dbg_cmd_code), .dbg_cmd_data(dbg_cmd_data),
    .dbg_resp_data(dbg_resp_data), .dbg_resp_valid(dbg_resp_valid), .dbg_resp_stop_error(dbg_resp_stop_error),
    .regulator_on(regulator_on), .regulator_standby(regulator_standby), .param_regs_on(param_regs_on),
    .high_freq_oscillator_on(high_freq_oscillator_on), .core_on(core_on), .core_standby(core_standby),
    .flash_on(flash_on), .flash_standby(flash_standby), .ram_on(ram_on),
    .timer_pwm_unit_clk_on(timer_pwm_unit_clk_on), .periph_clk_on(periph_clk_on),
    .wakeup_lf_clk_on(wakeup_lf_clk_on), .sys_clk_on(sys_clk_on), .debug_clk_on(debug_clk_on),
    .pin_latch_hold(pin_latch_hold), .pins_hiz(pins_hiz), .pin_port_ctrl(pin_port_ctrl),
    .low_voltage_detect(low_voltage_detect), .take_reset_vector(take_reset_vector),
    .take_irq_vector(take_irq_vector), .illegal_opcode_reset(illegal_opcode_reset),
    .halted_debug_state(halted_debug_state)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rst();
    @(posedge sys_clk);
    rstn <= 1'b0;
    wake_irq_pin <= 1'b0;
    wake_reset_pin <= 1'b0;
    supply_rearmed_pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic dbg(input logic [1:0] c, input logic [7:0] d);
    @(posedge sys_clk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd_code <= c;
    dbg_cmd_data <= d;
    @(posedge sys_clk);
    dbg_cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic stop_pulse();
    @(posedge sys_clk);
    stop_exec <= 1'b1;
    @(posedge sys_clk);
    stop_exec <= 1'b0;
  endtask

  task automatic enter(input logic [7:0] mode);
    wr(smpc_pkg::ADDR_MODE_CTRL, mode);
    stop_pulse();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // collects restart pulses from the current cycle on, over n more cycles
  task automatic await(input int n, output logic [2:0] s);
    #1;
    s = pulses;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      s = s | pulses;
    end
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    rst();
    @(posedge sys_clk);
    #1;
    chk(pwr, 8'h57);
    chk(clks, 8'hf8);
    rd(smpc_pkg::ADDR_STATUS, rdv);
    chk(rdv, 8'h00);
    rd(smpc_pkg::ADDR_DEBUG_CTRL, rdv);
    chk(rdv, 8'h00);
    rd(4'hc, rdv);
    chk(rdv, 8'h00);
    $display("test reset done");
    wr(smpc_pkg::ADDR_MODE_CTRL, 8'h01);
    stop_pulse();
    await(6, seen);
    chk({5'h0, seen}, 8'h01);
    chk(pwr, 8'h57);
    $display("test stop disabled done");
    enter(8'h11);
    chk(pwr, 8'h85);
    chk(clks, 8'h21);
    wake_irq_pin <= 1'b1;
    await(8, seen);
    wake_irq_pin <= 1'b0;
    chk({5'h0, seen}, 8'h04);
    await(2, seen);
    chk({7'h0, pin_latch_hold}, 8'h01);
    rd(smpc_pkg::ADDR_STATUS, rdv);
    chk(rdv, 8'h03);
    rd(smpc_pkg::ADDR_MODE_CTRL, rdv);
    chk(rdv, 8'h00);
    wr(smpc_pkg::ADDR_MODE_CTRL, 8'h20);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({6'h0, pin_latch_hold, pin_port_ctrl}, 8'h01);
    periph_enabled <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({7'h0, pin_port_ctrl}, 8'h00);
    rd(smpc_pkg::ADDR_STATUS, rdv);
    chk(rdv, 8'h00);
    $display("test stop2 done");
    rst();
    enter(8'h10);
    chk(pwr, 8'h81);
    chk(clks, 8'h26);
    chk({7'h0, regulator_on}, 8'h00);
    wake_irq_pin <= 1'b1;
    await(8, seen);
    chk({5'h0, seen}, 8'h00);
    supply_rearmed_pin <= 1'b1;
    await(8, seen);
    chk({5'h0, seen}, 8'h04);
    wake_irq_pin <= 1'b0;
    $display("test stop1 done");
    rst();
    enter(8'h12);
    chk(pwr, 8'had);
    chk(clks, 8'h20);
    chk({7'h0, regulator_on}, 8'h00);
    wake_irq_pin <= 1'b1;
    await(8, seen);
    chk({5'h0, seen}, 8'h02);
    rst();
    enter(8'h12);
    wake_irq_pin <= 1'b1;
    wake_reset_pin <= 1'b1;
    await(8, seen);
    chk({5'h0, seen}, 8'h04);
    $display("test stop3 done");
    rst();
    enter(8'h13);
    chk(pwr, 8'h2d);
    chk({7'h0, regulator_on}, 8'h01);
    wake_irq_pin <= 1'b1;
    await(8, seen);
    chk({5'h0, seen}, 8'h02);
    rst();
    enter(8'h1d);
    chk(pwr, 8'h2d);
    chk(clks, 8'h20);
    $display("test stop4 done");
    rst();
    dbg(smpc_pkg::DBG_BACKGROUND, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({7'h0, halted_debug_state}, 8'h00);
    dbg(smpc_pkg::DBG_WRITE_CONTROL, 8'h80);
    dbg(smpc_pkg::DBG_READ_STATUS, 8'h00);
    chk({6'h0, dbg_resp_valid, dbg_resp_data[7]}, 8'h03);
    enter(8'h10);
    chk(pwr, 8'h2d);
    chk(clks, 8'h38);
    dbg(smpc_pkg::DBG_MEM_STATUS, 8'h00);
    chk({7'h0, dbg_resp_stop_error}, 8'h01);
    dbg(smpc_pkg::DBG_BACKGROUND, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({7'h0, halted_debug_state}, 8'h01);
    $display("test debug done");
    conclude();
  end
endmodule // smpc_tb_top
